// file: verilog/power_saving_mode_control.sv
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/100ps
// What this block does
// - while the permit pin is high both entry sequences are ignored.
// - idle or power-down is entered only while the permit pin is low.
// - power-down stops the oscillator and all clocks; register state is kept.
// - power-down freezes alternate outputs at their last value; clock output stops low.
// - in power-down the address latch and fetch strobes are held low.
// - setting power-down arm and trigger together does not enter power-down.
// - power-down arm and trigger bits self-clear and always read zero.
// - the trigger write completes as the last instruction before power-down.
// - when idle and power-down are both triggered, power-down wins.
// - only a hardware reset leaves power-down; memory contents are untouched.
// - the exit reset restarts the oscillator; it must be held long enough.
// - in idle the oscillator and peripheral clocks except the watchdog run, the cpu clock stops.
// - idle keeps all cpu state by stopping the cpu and watchdog clocks only.
// - in idle latched pins hold and active alternate outputs keep driving.
// - in idle the address latch and fetch strobes are held high.
// - port inputs and peripheral clocks other than the watchdog clock stay live in idle.
// - after an external fetch port 0 floats; port 2 gives address in idle only.
// - the watchdog clock is the only peripheral clock stopped in idle.
// - idle arm and trigger together do nothing; both self-clear and read zero.
// - the idle trigger write is the last instruction before the cpu clock stops.
// - any enabled interrupt ends idle and resumes the cpu.
// - a hardware reset also ends idle; two machine cycles suffice.
module power_saving_mode_control
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmc_pkg::ADDR_W-1:0] paddr,
    input wire logic [pmc_pkg::DATA_W-1:0] pwdata,
    output logic pready,
    output logic [pmc_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    // external permit pin, low allows power saving
    input wire logic power_save_permit_pin,
    // cpu core status
    input wire logic insn_retire,
    input wire logic ext_fetch,
    input wire logic irq_pending,
    // pin sources in normal operation
    input wire logic ale_run,
    input wire logic prog_fetch_strobe_run,
    input wire logic clock_output_run,
    input wire logic [7:0] alt_out_run,
    // pin drivers
    output logic ale_out,
    output logic prog_fetch_strobe,
    output logic clock_output_pin,
    output logic [7:0] alt_out,
    output logic port0_oe_n,
    output logic port2_addr_sel,
    // clock gates
    output logic osc_en,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic wdt_clk_en
);
    import pmc_pkg::*;

    typedef struct packed
    {
        mode_t mode;
        logic permit_s1;
        logic permit_s2;
        logic pd_arm;
        logic sl_arm;
        logic smod;
        logic gf1;
        logic gf0;
        logic ext_q;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic ale;
        logic fetch_strb;
        logic clk_pin;
        logic [7:0] alt;
        logic p0_oe_n;
        logic p2_addr;
        logic osc;
        logic cpu;
        logic periph;
        logic wdt;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic permit_low;
    logic wr_fire;
    logic [7:0] wd;
    logic pd_go;
    logic sl_go;

    assign permit_low = ~s_q.permit_s2;
    assign wr_fire = psel & penable & pwrite & s_q.pready & (paddr == PMC_CTRL_ADDR);
    assign wd = pwdata[7:0];

    // a trigger only counts with its own arm from the previous instruction
    assign pd_go = wr_fire & (s_q.mode == MODE_RUN) & permit_low & s_q.pd_arm
        & wd[PDOWN_TRIG_BIT] & ~wd[PDOWN_ARM_BIT];
    assign sl_go = wr_fire & (s_q.mode == MODE_RUN) & permit_low & s_q.sl_arm
        & wd[SLEEP_TRIG_BIT] & ~wd[SLEEP_ARM_BIT];

    always_comb
    begin
        s_d = s_q;
        s_d.permit_s1 = power_save_permit_pin;
        s_d.permit_s2 = s_q.permit_s1;

        // apb: answer in the access phase that follows each setup
        s_d.pready = psel & ~penable;
        s_d.pslverr = 1'b0;
        s_d.prdata = PRDATA_RESET;
        if (psel & ~penable)
        begin
            if (paddr == PMC_CTRL_ADDR)
            begin
                s_d.prdata[SMOD_BIT] = s_q.smod;
                s_d.prdata[GF1_BIT] = s_q.gf1;
                s_d.prdata[GF0_BIT] = s_q.gf0;
            end
            else if (paddr == PMC_STAT_ADDR)
            begin
                s_d.prdata[STAT_RUN_BIT] = s_q.mode == MODE_RUN;
                s_d.prdata[STAT_IDLE_BIT] = s_q.mode == MODE_IDLE;
                s_d.prdata[STAT_PDOWN_BIT] = s_q.mode == MODE_PDOWN;
                s_d.prdata[STAT_PERMIT_BIT] = s_q.permit_s2;
                s_d.prdata[STAT_PD_ARMED_BIT] = s_q.pd_arm;
                s_d.prdata[STAT_SL_ARMED_BIT] = s_q.sl_arm;
                s_d.prdata[STAT_EXT_FETCH_BIT] = s_q.ext_q;
            end
            else
            begin
                s_d.pslverr = 1'b1;
            end
        end

        // any other instruction retiring drops a pending arm
        if (insn_retire)
        begin
            s_d.pd_arm = 1'b0;
            s_d.sl_arm = 1'b0;
        end

        // control write; the cpu is halted outside run so writes are dropped
        if (wr_fire && s_q.mode == MODE_RUN)
        begin
            s_d.smod = wd[SMOD_BIT];
            s_d.gf1 = wd[GF1_BIT];
            s_d.gf0 = wd[GF0_BIT];
            // arm holds for one instruction only, and only alone
            s_d.pd_arm = permit_low & wd[PDOWN_ARM_BIT] & ~wd[PDOWN_TRIG_BIT];
            s_d.sl_arm = permit_low & wd[SLEEP_ARM_BIT] & ~wd[SLEEP_TRIG_BIT];
        end

        // mode sequencing
        case (s_q.mode)
            MODE_RUN:
            begin
                s_d.ext_q = ext_fetch;
                if (pd_go)
                begin
                    s_d.mode = MODE_PDOWN;
                end
                else if (sl_go)
                begin
                    s_d.mode = MODE_IDLE;
                end
            end
            MODE_IDLE:
            begin
                if (irq_pending)
                begin
                    s_d.mode = MODE_RUN;
                end
            end
            MODE_PDOWN:
            begin
                s_d.mode = MODE_PDOWN;
            end
            default:
            begin
                s_d.mode = MODE_RUN;
            end
        endcase
        if (s_d.mode != MODE_RUN)
        begin
            s_d.pd_arm = 1'b0;
            s_d.sl_arm = 1'b0;
        end

        // pins and clock gates follow the next mode
        s_d.osc = s_d.mode != MODE_PDOWN;
        s_d.periph = s_d.mode != MODE_PDOWN;
        s_d.cpu = s_d.mode == MODE_RUN;
        s_d.wdt = s_d.mode == MODE_RUN;
        case (s_d.mode)
            MODE_IDLE:
            begin
                s_d.ale = 1'b1;
                s_d.fetch_strb = 1'b1;
                s_d.clk_pin = clock_output_run;
                s_d.alt = alt_out_run;
                s_d.p0_oe_n = s_d.ext_q;
                s_d.p2_addr = s_d.ext_q;
            end
            MODE_PDOWN:
            begin
                s_d.ale = 1'b0;
                s_d.fetch_strb = 1'b0;
                s_d.clk_pin = 1'b0;
                s_d.alt = (s_q.mode == MODE_RUN) ? alt_out_run : s_q.alt;
                s_d.p0_oe_n = s_d.ext_q;
                s_d.p2_addr = 1'b0;
            end
            default:
            begin
                s_d.ale = ale_run;
                s_d.fetch_strb = prog_fetch_strobe_run;
                s_d.clk_pin = clock_output_run;
                s_d.alt = alt_out_run;
                s_d.p0_oe_n = 1'b0;
                s_d.p2_addr = ext_fetch;
            end
        endcase
    end

    // reset ends either saving mode and frees the oscillator
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '{mode: MODE_RUN, permit_s1: 1'b1, permit_s2: 1'b1,
                     pd_arm: 1'b0, sl_arm: 1'b0, smod: PMC_CTRL_RESET[SMOD_BIT],
                     gf1: PMC_CTRL_RESET[GF1_BIT], gf0: PMC_CTRL_RESET[GF0_BIT],
                     ext_q: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: PRDATA_RESET,
                     ale: 1'b0, fetch_strb: 1'b1, clk_pin: 1'b0, alt: ALT_OUT_RESET,
                     p0_oe_n: 1'b0, p2_addr: 1'b0, osc: 1'b1, cpu: 1'b1,
                     periph: 1'b1, wdt: 1'b1};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pready = s_q.pready;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign ale_out = s_q.ale;
    assign prog_fetch_strobe = s_q.fetch_strb;
    assign clock_output_pin = s_q.clk_pin;
    assign alt_out = s_q.alt;
    assign port0_oe_n = s_q.p0_oe_n;
    assign port2_addr_sel = s_q.p2_addr;
    assign osc_en = s_q.osc;
    assign cpu_clk_en = s_q.cpu;
    assign periph_clk_en = s_q.periph;
    assign wdt_clk_en = s_q.wdt;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_permit_blocks;
        (s_q.mode == MODE_RUN) && s_q.permit_s2 |=> s_q.mode == MODE_RUN;
    endproperty
    a_permit_blocks: assert property (p_permit_blocks)
        else $error("saving mode entered while permit pin high");

    property p_pd_clocks;
        (s_q.mode == MODE_PDOWN) |-> !osc_en && !cpu_clk_en && !periph_clk_en && !wdt_clk_en;
    endproperty
    a_pd_clocks: assert property (p_pd_clocks)
        else $error("clock running in power-down");

    property p_pd_alt_hold;
        (s_q.mode == MODE_PDOWN) && $past(s_q.mode == MODE_PDOWN) |-> $stable(alt_out) && !clock_output_pin;
    endproperty
    a_pd_alt_hold: assert property (p_pd_alt_hold)
        else $error("alternate output moved in power-down");

    property p_pd_strobes;
        (s_q.mode == MODE_PDOWN) |-> !ale_out && !prog_fetch_strobe;
    endproperty
    a_pd_strobes: assert property (p_pd_strobes)
        else $error("strobes not low in power-down");

    property p_both_bits;
        wr_fire && wd[PDOWN_ARM_BIT] && wd[PDOWN_TRIG_BIT] |=> !s_q.pd_arm;
    endproperty
    a_both_bits: assert property (p_both_bits)
        else $error("power-down armed by combined write");

    property p_read_zero;
        pready && !pslverr && $past(paddr == PMC_CTRL_ADDR) |->
            !prdata[PDOWN_ARM_BIT] && !prdata[PDOWN_TRIG_BIT] && !prdata[SLEEP_ARM_BIT] && !prdata[SLEEP_TRIG_BIT];
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("arm or trigger bit read as one");

    property p_pd_entry;
        pd_go |=> (s_q.mode == MODE_PDOWN) ##1 (s_q.mode == MODE_PDOWN);
    endproperty
    a_pd_entry: assert property (p_pd_entry)
        else $error("power-down not entered after trigger");

    property p_idle_entry;
        sl_go && !pd_go |=> (s_q.mode == MODE_IDLE) && !cpu_clk_en && osc_en && periph_clk_en && !wdt_clk_en;
    endproperty
    a_idle_entry: assert property (p_idle_entry)
        else $error("idle not entered correctly");

    property p_idle_strobes;
        (s_q.mode == MODE_IDLE) |-> ale_out && prog_fetch_strobe && (port0_oe_n == s_q.ext_q);
    endproperty
    a_idle_strobes: assert property (p_idle_strobes)
        else $error("idle pin state wrong");

    property p_idle_exit;
        (s_q.mode == MODE_IDLE) && irq_pending |=> (s_q.mode == MODE_RUN) && cpu_clk_en;
    endproperty
    a_idle_exit: assert property (p_idle_exit)
        else $error("interrupt did not end idle");

    property p_arm_drop;
        s_q.pd_arm && insn_retire && !wr_fire |=> !s_q.pd_arm;
    endproperty
    a_arm_drop: assert property (p_arm_drop)
        else $error("arm survived another instruction");

endmodule : power_saving_mode_control

// file: verilog/pmc_pkg.sv
package pmc_pkg;

    // apb geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register byte addresses
    localparam logic [11:0] PMC_CTRL_ADDR = 12'h000;
    localparam logic [11:0] PMC_STAT_ADDR = 12'h004;

    // control register field positions
    localparam int SLEEP_ARM_BIT = 0;
    localparam int PDOWN_ARM_BIT = 1;
    localparam int GF0_BIT = 2;
    localparam int GF1_BIT = 3;
    localparam int SLEEP_TRIG_BIT = 5;
    localparam int PDOWN_TRIG_BIT = 6;
    localparam int SMOD_BIT = 7;

    // status register field positions
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_IDLE_BIT = 1;
    localparam int STAT_PDOWN_BIT = 2;
    localparam int STAT_PERMIT_BIT = 3;
    localparam int STAT_PD_ARMED_BIT = 4;
    localparam int STAT_SL_ARMED_BIT = 5;
    localparam int STAT_EXT_FETCH_BIT = 6;

    // reset values
    localparam logic [7:0] PMC_CTRL_RESET = 8'h00;
    localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;
    localparam logic [7:0] ALT_OUT_RESET = 8'h00;

    // one-hot operating modes
    typedef enum logic [2:0]
    {
        MODE_RUN = 3'b001,
        MODE_IDLE = 3'b010,
        MODE_PDOWN = 3'b100
    } mode_t;

    // machine cycles a reset must span to end idle
    localparam int IDLE_RESET_CYCLES = 2;

endpackage : pmc_pkg

// file: dv/cpu_side_model.sv
`timescale 1ns/100ps
// stands in for the cpu core and the power-fail circuit
module cpu_side_model
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench controls
    input wire logic fail_warn,
    input wire logic retire_req,
    input wire logic irq_req,
    input wire logic from_ext,
    input wire logic [7:0] alt_val,
    // block inputs
    output logic power_save_permit_pin,
    output logic insn_retire,
    output logic ext_fetch,
    output logic irq_pending,
    output logic ale_run,
    output logic prog_fetch_strobe_run,
    output logic clock_output_run,
    output logic [7:0] alt_out_run
);
    // pullup keeps saving blocked unless the power-fail warning pulls low
    assign power_save_permit_pin = ~fail_warn;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            insn_retire <= 1'b0;
            ext_fetch <= 1'b0;
            irq_pending <= 1'b0;
            ale_run <= 1'b0;
            prog_fetch_strobe_run <= 1'b1;
            clock_output_run <= 1'b0;
            alt_out_run <= 8'h00;
        end
        else
        begin
            insn_retire <= retire_req;
            ext_fetch <= from_ext;
            irq_pending <= irq_req;
            // strobes and clock output keep toggling so a held level shows
            ale_run <= ~ale_run;
            prog_fetch_strobe_run <= ale_run;
            clock_output_run <= ~clock_output_run;
            alt_out_run <= alt_val;
        end
    end
endmodule : cpu_side_model

// file: dv/tb.sv
`timescale 1ns/100ps
module tb;
    import pmc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rerr;
    logic fail_warn, retire_req, irq_req, from_ext;
    logic [7:0] alt_val, alt_out, alt_out_run;
    logic permit, retire, extf, irqp, ale_run, pfs_run, clko_run;
    logic ale_out, pfs, clko, p0_oe_n, p2_sel, osc_en, cpu_en, per_en, wdt_en;
    int err_count, comparisons;

    always #5 pclk = ~pclk;

    cpu_side_model i_cpu_side_model (.pclk(pclk), .presetn(presetn), .fail_warn(fail_warn),
        .retire_req(retire_req), .irq_req(irq_req), .from_ext(from_ext), .alt_val(alt_val),
        .power_save_permit_pin(permit), .insn_retire(retire), .ext_fetch(extf), .irq_pending(irqp),
        .ale_run(ale_run), .prog_fetch_strobe_run(pfs_run), .clock_output_run(clko_run),
        .alt_out_run(alt_out_run));

    power_saving_mode_control i_power_saving_mode_control (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .power_save_permit_pin(permit),
        .insn_retire(retire), .ext_fetch(extf), .irq_pending(irqp), .ale_run(ale_run),
        .prog_fetch_strobe_run(pfs_run), .clock_output_run(clko_run), .alt_out_run(alt_out_run),
        .ale_out(ale_out), .prog_fetch_strobe(pfs), .clock_output_pin(clko), .alt_out(alt_out),
        .port0_oe_n(p0_oe_n), .port2_addr_sel(p2_sel), .osc_en(osc_en), .cpu_clk_en(cpu_en),
        .periph_clk_en(per_en), .wdt_clk_en(wdt_en));

    task close_out;
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task cyc(input int n);
        repeat (n) @(negedge pclk);
    endtask : cyc

    task do_reset;
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    task mode_is(input logic [2:0] m);
        apb(PMC_STAT_ADDR, 1'b0, 32'h0);
        check("mode", rd & 32'h7, {29'h0, m});
    endtask : mode_is

    initial
    begin
        repeat (5000) @(posedge pclk);
        err_count++;
        close_out;
    end

    initial
    begin
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, retire_req, irq_req, from_ext} = 6'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fail_warn = 0;
        alt_val = 8'h00;
        do_reset;
        apb(PMC_CTRL_ADDR, 1'b0, 32'h0);
        check("ctrl reset", rd, 32'h0);
        check("clocks", {osc_en, cpu_en, per_en, wdt_en}, 32'hf);
        apb(12'h008, 1'b0, 32'h0);
        check("slverr", {31'h0, rerr}, 32'h1);
        check("unmapped read", rd, 32'h0);
        apb(PMC_CTRL_ADDR, 1'b1, 32'h02);
        apb(PMC_CTRL_ADDR, 1'b1, 32'h40);
        apb(PMC_CTRL_ADDR, 1'b1, 32'h01);
        apb(PMC_CTRL_ADDR, 1'b1, 32'h20);
        mode_is(3'h1);
        fail_warn <= 1'b1;
        cyc(4);
        apb(PMC_CTRL_ADDR, 1'b1, 32'hef);
        apb(PMC_CTRL_ADDR, 1'b0, 32'h0);
        check("ctrl read", rd, 32'h8c);
        mode_is(3'h1);
        apb(PMC_CTRL_ADDR, 1'b1, 32'h02);
        @(posedge pclk) retire_req <= 1'b1;
        @(posedge pclk) retire_req <= 1'b0;
        cyc(2);
        apb(PMC_CTRL_ADDR, 1'b1, 32'h40);
        mode_is(3'h1);
        from_ext <= 1'b1;
        apb(PMC_CTRL_ADDR, 1'b1, 32'h01);
        apb(PMC_CTRL_ADDR, 1'b1, 32'h20);
        mode_is(3'h2);
        cyc(1);
        check("idle clocks", {osc_en, cpu_en, per_en, wdt_en}, 32'ha);
        check("idle strobes", {ale_out, pfs, p0_oe_n, p2_sel}, 32'hf);
        cyc(1);
        check("idle strobes", {ale_out, pfs}, 32'h3);
        @(posedge pclk) irq_req <= 1'b1;
        cyc(3);
        @(posedge pclk) irq_req <= 1'b0;
        mode_is(3'h1);
        alt_val <= 8'ha5;
        apb(PMC_CTRL_ADDR, 1'b1, 32'h03);
        apb(PMC_CTRL_ADDR, 1'b1, 32'h60);
        alt_val <= 8'h5a;
        cyc(3);
        check("pd clocks", {osc_en, cpu_en, per_en, wdt_en}, 32'h0);
        check("pd pins", {ale_out, pfs, clko, p0_oe_n, p2_sel}, 32'h2);
        check("pd alt", alt_out, 32'ha5);
        @(posedge pclk) irq_req <= 1'b1;
        cyc(3);
        check("pd clko", {clko, osc_en}, 32'h0);
        mode_is(3'h4);
        irq_req <= 1'b0;
        do_reset;
        cyc(1);
        check("exit clocks", {osc_en, cpu_en}, 32'h3);
        cyc(3);
        apb(PMC_CTRL_ADDR, 1'b1, 32'h02);
        apb(PMC_CTRL_ADDR, 1'b1, 32'h40);
        mode_is(3'h4);
        cyc(1);
        check("pd pins ext", {ale_out, pfs, clko, p0_oe_n, p2_sel}, 32'h2);
        close_out;
    end
endmodule : tb
